/* File: verilog/cantmc_params.svh */
`ifndef CANTMC_PARAMS_SVH
`define CANTMC_PARAMS_SVH

// register byte offsets
`define CANTMC_CTRL_OFS 8'h00
`define CANTMC_STATUS_OFS 8'h04
`define CANTMC_IRQ_STAT_OFS 8'h08
`define CANTMC_IRQ_MASK_OFS 8'h0c

// control register fields
`define CANTMC_CTRL_MC_LSB 0
`define CANTMC_CTRL_MC_MSB 2
`define CANTMC_CTRL_SWK_BIT 3
`define CANTMC_SWK_RST 1'b0

// mode-change command codes
`define CANTMC_MC_SLEEP 3'h1
`define CANTMC_MC_STANDBY 3'h2
`define CANTMC_MC_RX_ONLY 3'h3
`define CANTMC_MC_NORMAL 3'h4

// mode codes shown in the status register
`define CANTMC_CODE_POWER_UP 3'h0
`define CANTMC_CODE_NORMAL 3'h1
`define CANTMC_CODE_RX_ONLY 3'h2
`define CANTMC_CODE_STANDBY 3'h3
`define CANTMC_CODE_SLEEP_WUP 3'h4
`define CANTMC_CODE_SEL_WAKE 3'h5
`define CANTMC_CODE_SEL_SLEEP 3'h6

// status register fields
`define CANTMC_ST_MODE_LSB 0
`define CANTMC_ST_MODE_MSB 2
`define CANTMC_ST_SWK_BIT 3
`define CANTMC_ST_WUP_BIT 4
`define CANTMC_ST_VIO_UV_BIT 5
`define CANTMC_ST_VCC_UV_BIT 6
`define CANTMC_ST_SILENCE_BIT 7
`define CANTMC_ST_PEND_BIT 8

// interrupt status and mask fields
`define CANTMC_IRQ_W 5
`define CANTMC_IRQ_WUP_BIT 0
`define CANTMC_IRQ_WUF_BIT 1
`define CANTMC_IRQ_LWU_BIT 2
`define CANTMC_IRQ_UVSLP_BIT 3
`define CANTMC_IRQ_STBY_BIT 4
`define CANTMC_IRQ_MASK_RST 5'h00

// timing: clock rate and times in microseconds
`define CANTMC_CLK_MHZ 200
`define CANTMC_PON_US 100
`define CANTMC_VIO_UV_US 100
`define CANTMC_VCC_UV_US 100
`define CANTMC_SILENCE_US 1000

// axi response codes
`define CANTMC_RESP_OKAY 2'h0
`define CANTMC_RESP_SLVERR 2'h2

`endif

/* File: verilog/cantmc_pkg.sv */
package cantmc_pkg;

  // operating modes and sleep sub-modes
  typedef enum logic [2:0] {
    power_up,
    normal_mode,
    rx_only_mode,
    standby_mode,
    sleep_wup,
    sel_wake,
    sel_sleep
  } cantmc_mode_t;

  // function enables derived from the mode
  typedef struct packed {
    logic tx_active;
    logic rx_normal;
    logic bias_on;
    logic txd_timeout_en;
    logic overtemp_en;
    logic uv_detect_en;
    logic supply_switch;
    logic wup_flag_en;
    logic wuf_monitor_en;
    logic local_wake_en;
  } cantmc_ctrl_t;

  // synchronised pin levels
  typedef struct packed {
    logic txd;
    logic bus_dom;
    logic vio_uv;
    logic vcc_uv;
    logic vbat_ok;
    logic vcc_ok;
    logic local_wake;
  } cantmc_pins_t;

endpackage : cantmc_pkg

/* File: verilog/cantmc_top.sv */
// Function
// - low transmit input drives dominant, rx follows
// - transmit and monitor bus at once
// - low-power modes detect and signal wakes
// - four modes, sleep has three sub-modes
// - normal mode: transmitter and receiver active
// - normal: bias, timeout, overtemperature enabled
// - normal, rx-only: undervoltage detect, switch high
// - normal, rx-only: wake pattern flag not set
// - normal, rx-only: frame monitor only if enabled
// - normal, rx-only: local wake disabled
// - command enters normal from any mode except power-up
// - undervoltage, filter and silence expired: sleep
// - command requesting other mode leaves mode
// - rx-only: transmitter off, input blocked
// - rx-only: receiver output, bias on
// - rx-only: timeout, overtemperature disabled
// - command enters rx-only from any mode except power-up
// - power-on delay elapsed: enter stand-by
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "cantmc_params.svh"

// three-stage pin synchroniser, output moves when stages two and three agree
module cantmc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // shift chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // agreement filter per bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          q[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule : cantmc_sync

// qualification timer: counts while qual is high, restarts when it drops
module cantmc_qual_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic qual,
  output logic expired
);
  logic [31:0] cnt_ff;

  // count up to the limit and hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
      expired <= 1'b0;
    end else if (!qual) begin
      cnt_ff <= 32'h0;
      expired <= 1'b0;
    end else if (cnt_ff < LIMIT) begin
      cnt_ff <= cnt_ff + 32'h1;
      expired <= (cnt_ff + 32'h1) >= LIMIT;
    end
  end
endmodule : cantmc_qual_timer

module cantmc_top #(
  parameter int unsigned PON_CYCLES = `CANTMC_PON_US * `CANTMC_CLK_MHZ,
  parameter int unsigned VIO_UV_CYCLES =
    `CANTMC_VIO_UV_US * `CANTMC_CLK_MHZ,
  parameter int unsigned VCC_UV_CYCLES =
    `CANTMC_VCC_UV_US * `CANTMC_CLK_MHZ,
  parameter int unsigned SILENCE_CYCLES =
    `CANTMC_SILENCE_US * `CANTMC_CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // controller side
  input wire logic txd_in,
  output logic rxd_out,
  // bus side
  input wire logic bus_dominant_in,
  output logic bus_drive_dominant,
  output logic bus_bias_on,
  // supply monitors and detectors
  input wire logic logic_ref_undervoltage_level,
  input wire logic tx_supply_undervoltage_level,
  input wire logic battery_supply_ok,
  input wire logic tx_supply_ok,
  input wire logic local_wake_in,
  input wire logic wake_pattern_det,
  input wire logic wake_frame,
  // function enables and interrupt request
  output logic txd_timeout_en,
  output logic overtemp_en,
  output logic undervoltage_det_en,
  output logic supply_switch_out,
  output logic wake_frame_monitor_en,
  output logic irq
);

  logic rst_a_ff;
  logic rst_n_ff;
  cantmc_pkg::cantmc_pins_t pins_raw;
  cantmc_pkg::cantmc_pins_t pins;
  cantmc_pkg::cantmc_mode_t mode_ff;
  cantmc_pkg::cantmc_mode_t nxt_mode;
  cantmc_pkg::cantmc_ctrl_t ctl;
  logic pon_done;
  logic vio_uv_exp;
  logic vcc_uv_exp;
  logic silence_exp;
  logic uv_sleep;
  logic lwake_d_ff;
  logic lwake_edge;
  logic wup_ev;
  logic wuf_ev;
  logic lwu_ev;
  logic selective_wake_enable_ff;
  logic wup_flag_ff;
  logic wake_pend_ff;
  logic [`CANTMC_IRQ_W-1:0] irq_stat_ff;
  logic [`CANTMC_IRQ_W-1:0] irq_mask_ff;
  logic [`CANTMC_IRQ_W-1:0] irq_set;
  logic [`CANTMC_IRQ_W-1:0] nxt_irq_stat;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic aw_take;
  logic w_take;
  logic wr_do;
  logic ar_take;
  logic mc_valid;
  logic [2:0] mc_code;
  logic rd_stat;
  logic rd_status;
  logic [31:0] status_word;
  logic [2:0] mode_code;

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n_ff <= rst_a_ff;
    end
  end

  // pins from outside the clock domain
  assign pins_raw = '{txd: txd_in, bus_dom: bus_dominant_in,
                      vio_uv: logic_ref_undervoltage_level,
                      vcc_uv: tx_supply_undervoltage_level,
                      vbat_ok: battery_supply_ok, vcc_ok: tx_supply_ok,
                      local_wake: local_wake_in};

  cantmc_sync #(
    .W($bits(cantmc_pkg::cantmc_pins_t)),
    .RST(7'h40)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n_ff),
    .d(pins_raw),
    .q(pins)
  );

  // supply filters, bus silence and power-on delay
  cantmc_qual_timer #(.LIMIT(VIO_UV_CYCLES)) u_vio_uv (
    .clk(clk), .rst_n(rst_n_ff), .qual(pins.vio_uv), .expired(vio_uv_exp)
  );
  cantmc_qual_timer #(.LIMIT(VCC_UV_CYCLES)) u_vcc_uv (
    .clk(clk), .rst_n(rst_n_ff), .qual(pins.vcc_uv), .expired(vcc_uv_exp)
  );
  cantmc_qual_timer #(.LIMIT(SILENCE_CYCLES)) u_silence (
    .clk(clk), .rst_n(rst_n_ff), .qual(!pins.bus_dom),
    .expired(silence_exp)
  );
  cantmc_qual_timer #(.LIMIT(PON_CYCLES)) u_pon (
    .clk(clk), .rst_n(rst_n_ff),
    .qual((pins.vbat_ok || pins.vcc_ok) && mode_ff == cantmc_pkg::power_up),
    .expired(pon_done)
  );

  // undervoltage on either supply, filter expired, plus bus silence forces sleep
  assign uv_sleep = (vio_uv_exp || vcc_uv_exp) && silence_exp;

  // function enables per mode
  always_comb begin
    ctl = '0;
    case (mode_ff)
      cantmc_pkg::normal_mode: begin
        ctl.tx_active = 1'b1;
        ctl.rx_normal = 1'b1;
        ctl.bias_on = 1'b1;
        ctl.txd_timeout_en = 1'b1;
        ctl.overtemp_en = 1'b1;
        ctl.uv_detect_en = 1'b1;
        ctl.supply_switch = 1'b1;
        ctl.wuf_monitor_en = selective_wake_enable_ff;
      end
      cantmc_pkg::rx_only_mode: begin
        ctl.rx_normal = 1'b1;
        ctl.bias_on = 1'b1;
        ctl.uv_detect_en = 1'b1;
        ctl.supply_switch = 1'b1;
        ctl.wuf_monitor_en = selective_wake_enable_ff;
      end
      cantmc_pkg::standby_mode: begin
        ctl.uv_detect_en = 1'b1;
        ctl.supply_switch = 1'b1;
        ctl.wup_flag_en = !selective_wake_enable_ff;
        ctl.wuf_monitor_en = selective_wake_enable_ff;
        ctl.local_wake_en = 1'b1;
      end
      cantmc_pkg::sleep_wup: begin
        ctl.bias_on = !silence_exp;
        ctl.wup_flag_en = 1'b1;
        ctl.local_wake_en = 1'b1;
      end
      cantmc_pkg::sel_wake: begin
        ctl.bias_on = 1'b1;
        ctl.wuf_monitor_en = 1'b1;
        ctl.local_wake_en = 1'b1;
      end
      cantmc_pkg::sel_sleep: begin
        ctl.local_wake_en = 1'b1;
      end
      default: begin
        ctl = '0;
      end
    endcase
  end

  // wake events gated by the function enables of the mode; wake pattern also taken in sel_sleep
  assign lwake_edge = pins.local_wake != lwake_d_ff;
  assign lwu_ev = lwake_edge && ctl.local_wake_en;
  assign wuf_ev = wake_frame && ctl.wuf_monitor_en;
  assign wup_ev = wake_pattern_det && (ctl.wup_flag_en ||
                  mode_ff == cantmc_pkg::sel_sleep);

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lwake_d_ff <= 1'b0;
    end else begin
      lwake_d_ff <= pins.local_wake;
    end
  end

  // mode state machine: command first, then supply sleep, then wakes
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      cantmc_pkg::power_up: begin
        if (pon_done) begin
          nxt_mode = cantmc_pkg::standby_mode;
        end
      end
      cantmc_pkg::normal_mode, cantmc_pkg::rx_only_mode,
      cantmc_pkg::standby_mode: begin
        if (uv_sleep) begin
          nxt_mode = cantmc_pkg::sleep_wup;
        end
      end
      cantmc_pkg::sleep_wup: begin
        if (wup_ev || lwu_ev) begin
          nxt_mode = cantmc_pkg::standby_mode;
        end
      end
      cantmc_pkg::sel_wake: begin
        if (wuf_ev || lwu_ev) begin
          nxt_mode = cantmc_pkg::standby_mode;
        end else if (silence_exp) begin
          nxt_mode = cantmc_pkg::sel_sleep;
        end
      end
      cantmc_pkg::sel_sleep: begin
        if (lwu_ev) begin
          nxt_mode = cantmc_pkg::standby_mode;
        end else if (wup_ev) begin
          nxt_mode = cantmc_pkg::sel_wake;
        end
      end
      default: begin
        nxt_mode = cantmc_pkg::power_up;
      end
    endcase
    if (mc_valid && mode_ff != cantmc_pkg::power_up) begin
      case (mc_code)
        `CANTMC_MC_NORMAL: nxt_mode = cantmc_pkg::normal_mode;
        `CANTMC_MC_RX_ONLY: nxt_mode = cantmc_pkg::rx_only_mode;
        `CANTMC_MC_STANDBY: nxt_mode = cantmc_pkg::standby_mode;
        `CANTMC_MC_SLEEP: begin
          nxt_mode = selective_wake_enable_ff ? cantmc_pkg::sel_wake
                               : cantmc_pkg::sleep_wup;
        end
        default: begin
          nxt_mode = nxt_mode;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mode_ff <= cantmc_pkg::power_up;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // data path and function enable outputs
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bus_drive_dominant <= 1'b0;
      rxd_out <= 1'b1;
      bus_bias_on <= 1'b0;
      txd_timeout_en <= 1'b0;
      overtemp_en <= 1'b0;
      undervoltage_det_en <= 1'b0;
      supply_switch_out <= 1'b0;
      wake_frame_monitor_en <= 1'b0;
    end else begin
      bus_drive_dominant <= ctl.tx_active && !pins.txd;
      rxd_out <= ctl.rx_normal ? !pins.bus_dom
                               : !wake_pend_ff;
      bus_bias_on <= ctl.bias_on;
      txd_timeout_en <= ctl.txd_timeout_en;
      overtemp_en <= ctl.overtemp_en;
      undervoltage_det_en <= ctl.uv_detect_en;
      supply_switch_out <= ctl.supply_switch;
      wake_frame_monitor_en <= ctl.wuf_monitor_en;
    end
  end

  // axi write channel handshakes
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_do = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CANTMC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      aw_got_ff <= (aw_got_ff || aw_take) && !wr_do;
      w_got_ff <= (w_got_ff || w_take) && !wr_do;
      s_axi_awready <= !(aw_got_ff || aw_take) || wr_do;
      s_axi_wready <= !(w_got_ff || w_take) || wr_do;
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_ff[7:2] <= `CANTMC_IRQ_MASK_OFS >> 2)
                       ? `CANTMC_RESP_OKAY : `CANTMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes: control issues a mode-change command
  assign mc_valid = wr_do && w_strb_ff[0] &&
                    aw_addr_ff[7:2] == `CANTMC_CTRL_OFS >> 2;
  assign mc_code = w_data_ff[`CANTMC_CTRL_MC_MSB:`CANTMC_CTRL_MC_LSB];

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      selective_wake_enable_ff <= `CANTMC_SWK_RST;
      irq_mask_ff <= `CANTMC_IRQ_MASK_RST;
    end else if (wr_do && w_strb_ff[0]) begin
      if (aw_addr_ff[7:2] == `CANTMC_CTRL_OFS >> 2) begin
        selective_wake_enable_ff <= w_data_ff[`CANTMC_CTRL_SWK_BIT];
      end
      if (aw_addr_ff[7:2] == `CANTMC_IRQ_MASK_OFS >> 2) begin
        irq_mask_ff <= w_data_ff[`CANTMC_IRQ_W-1:0];
      end
    end
  end

  // axi read channel
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_stat = ar_take && s_axi_araddr[7:2] == `CANTMC_IRQ_STAT_OFS >> 2;
  assign rd_status = ar_take && s_axi_araddr[7:2] == `CANTMC_STATUS_OFS >> 2;

  always_comb begin
    case (mode_ff)
      cantmc_pkg::normal_mode: mode_code = `CANTMC_CODE_NORMAL;
      cantmc_pkg::rx_only_mode: mode_code = `CANTMC_CODE_RX_ONLY;
      cantmc_pkg::standby_mode: mode_code = `CANTMC_CODE_STANDBY;
      cantmc_pkg::sleep_wup: mode_code = `CANTMC_CODE_SLEEP_WUP;
      cantmc_pkg::sel_wake: mode_code = `CANTMC_CODE_SEL_WAKE;
      cantmc_pkg::sel_sleep: mode_code = `CANTMC_CODE_SEL_SLEEP;
      default: mode_code = `CANTMC_CODE_POWER_UP;
    endcase
    status_word = 32'h0;
    status_word[`CANTMC_ST_MODE_MSB:`CANTMC_ST_MODE_LSB] = mode_code;
    status_word[`CANTMC_ST_SWK_BIT] = selective_wake_enable_ff;
    status_word[`CANTMC_ST_WUP_BIT] = wup_flag_ff;
    status_word[`CANTMC_ST_VIO_UV_BIT] = vio_uv_exp;
    status_word[`CANTMC_ST_VCC_UV_BIT] = vcc_uv_exp;
    status_word[`CANTMC_ST_SILENCE_BIT] = silence_exp;
    status_word[`CANTMC_ST_PEND_BIT] = wake_pend_ff;
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CANTMC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CANTMC_RESP_OKAY;
        case (s_axi_araddr[7:2])
          `CANTMC_CTRL_OFS >> 2: begin
            s_axi_rdata <= {28'h0, selective_wake_enable_ff, 3'h0};
          end
          `CANTMC_STATUS_OFS >> 2: s_axi_rdata <= status_word;
          `CANTMC_IRQ_STAT_OFS >> 2: s_axi_rdata <= {27'h0, irq_stat_ff};
          `CANTMC_IRQ_MASK_OFS >> 2: s_axi_rdata <= {27'h0, irq_mask_ff};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `CANTMC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // wake flag, pending wake and sticky interrupt status; set beats clear
  assign irq_set[`CANTMC_IRQ_WUP_BIT] = wup_ev;
  assign irq_set[`CANTMC_IRQ_WUF_BIT] = wuf_ev;
  assign irq_set[`CANTMC_IRQ_LWU_BIT] = lwu_ev;
  // entry only, not every cycle spent in sleep under undervoltage
  assign irq_set[`CANTMC_IRQ_UVSLP_BIT] =
    nxt_mode == cantmc_pkg::sleep_wup &&
    mode_ff != cantmc_pkg::sleep_wup && uv_sleep && !mc_valid;
  assign irq_set[`CANTMC_IRQ_STBY_BIT] =
    mode_ff == cantmc_pkg::power_up && nxt_mode != mode_ff;
  assign nxt_irq_stat = (rd_stat ? '0 : irq_stat_ff) | irq_set;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_stat_ff <= '0;
      irq <= 1'b0;
      wup_flag_ff <= 1'b0;
      wake_pend_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq <= |(nxt_irq_stat & irq_mask_ff);
      wup_flag_ff <= (wup_flag_ff && !rd_status) ||
                     (wup_ev && ctl.wup_flag_en);
      wake_pend_ff <= (wake_pend_ff && !ctl.rx_normal) ||
                      wup_ev || wuf_ev || lwu_ev;
    end
  end

endmodule : cantmc_top

/* File: verif/cantmc_props.sv */
`timescale 1ns/10ps
`include "cantmc_params.svh"
module cantmc_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic txd_in,
  input wire logic rxd_out,
  input wire logic bus_dominant_in,
  input wire logic bus_drive_dominant,
  input wire logic bus_bias_on,
  input wire logic txd_timeout_en,
  input wire logic overtemp_en,
  input wire logic undervoltage_det_en,
  input wire logic supply_switch_out
);
  // receiver active: switch high with bias on
  logic act;
  assign act = supply_switch_out & bus_bias_on;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_tx_gate: assert property (bus_drive_dominant |->
    txd_timeout_en || $past(txd_timeout_en))
    else $error("bus driven outside normal mode");
  a_prot_tie: assert property (txd_timeout_en == overtemp_en)
    else $error("timeout and overtemp enables differ");
  a_norm_en: assert property (txd_timeout_en |->
    bus_bias_on && supply_switch_out && undervoltage_det_en)
    else $error("normal mode enables wrong");
  a_switch_uv: assert property (act |-> undervoltage_det_en)
    else $error("undervoltage detect off while active");
  a_rx_follow: assert property (
    (act && $stable(bus_dominant_in)) [*6] |-> rxd_out == !bus_dominant_in)
    else $error("receive output does not follow bus");
  a_tx_path: assert property (
    (txd_timeout_en && $stable(txd_in)) [*6] |->
    bus_drive_dominant == !txd_in)
    else $error("transmit path wrong");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response changed");
  c_uv_sleep: cover property ($fell(supply_switch_out));
  c_normal: cover property ($rose(txd_timeout_en));
  c_slverr: cover property (s_axi_rvalid &&
    s_axi_rresp == `CANTMC_RESP_SLVERR);
endmodule : cantmc_props

/* File: verif/cantmc_ctrl_model.sv */
`timescale 1ns/10ps
// controller pin plus a wired bus shared with one far node
module cantmc_ctrl_model (
  input wire logic tx_bit,
  input wire logic far_dom,
  input wire logic drive_dom,
  output logic txd_in,
  output logic bus_dom
);
  // low bit sent means dominant request
  assign txd_in = tx_bit;
  // dominant wins on the bus, recessive by termination otherwise
  assign bus_dom = drive_dom | far_dom;
endmodule : cantmc_ctrl_model

/* File: verif/can_transceiver_mode_control_tb.sv */
`timescale 1ns/10ps
`include "cantmc_params.svh"
module can_transceiver_mode_control_tb;
  typedef struct packed {
    logic [31:0] m;
    logic [31:0] e;
    logic [1:0] r;
  } cantmc_exp_t;
  localparam logic [7:0] ca = `CANTMC_CTRL_OFS, sa = `CANTMC_STATUS_OFS;
  localparam logic [7:0] ia = `CANTMC_IRQ_STAT_OFS, ma = `CANTMC_IRQ_MASK_OFS;
  localparam logic [1:0] ok = `CANTMC_RESP_OKAY, er = `CANTMC_RESP_SLVERR;
  logic clk = 1'b0, reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, rxd_out, txd_in, bus_dominant_in;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic bus_drive_dominant, bus_bias_on, txd_timeout_en, overtemp_en;
  logic undervoltage_det_en, supply_switch_out, wake_frame_monitor_en;
  logic logic_ref_undervoltage_level = 1'b0;
  logic tx_supply_undervoltage_level = 1'b0;
  logic tx_supply_ok = 1'b0, local_wake_in = 1'b0, wake_pattern_det = 1'b0;
  logic battery_supply_ok = 1'b0, wake_frame = 1'b0;
  logic tx_bit = 1'b1, far_dom = 1'b0, b, f;
  logic [3:0] cmd [7] = '{4'h3, 4'h2, 4'h4, 4'h1, 4'h3, 4'h7, 4'h4};
  logic [2:0] code [7] = '{3'h2, 3'h3, 3'h1, 3'h4, 3'h2, 3'h2, 3'h1};
  int n_fail = 0, checks_done = 0, cyc = 0;
  cantmc_exp_t rq[$];
  cantmc_exp_t ex;
  logic [1:0] bq[$];
  always #2.5 clk = ~clk;
  cantmc_top #(.PON_CYCLES(20), .VIO_UV_CYCLES(20), .VCC_UV_CYCLES(20),
    .SILENCE_CYCLES(40)) dut (.s_axi_wstrb(4'hf), .*);
  cantmc_ctrl_model ctl (.tx_bit(tx_bit), .far_dom(far_dom),
    .drive_dom(bus_drive_dominant), .txd_in(txd_in),
    .bus_dom(bus_dominant_in));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  // write both channels, hold each until taken, then take the response
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
    rq.push_back('{m, e, r});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // response monitor against queued notes, plus run limit
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      ex = rq.pop_front();
      chk(s_axi_rdata & ex.m, ex.e);
      chk(s_axi_rresp, ex.r);
    end
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'h410a3c87));
    tk(16);
    reset_n <= 1'b1;
    tx_supply_ok <= 1'b1;
    battery_supply_ok <= 1'($urandom);
    tk(8);
    wr(ma, 32'h0, ok);
    tk(40);
    chk(irq, 1'b0);
    rd(sa, 32'h7, 32'h3, ok);
    wr(ma, 32'h1f, ok);
    tk(2);
    chk(irq, 1'b1);
    rd(ia, 32'h1f, 32'h10, ok);
    tk(2);
    chk(irq, 1'b0);
    rd(8'h10, 32'hffffffff, 32'h0, er);
    wr(8'h14, 32'h0, er);
    $display("test startup done");
    wr(ca, 32'h4, ok);
    tk(3);
    chk({txd_timeout_en, overtemp_en, bus_bias_on, undervoltage_det_en,
      supply_switch_out, wake_frame_monitor_en}, 6'h3e);
    rd(sa, 32'h7, 32'h1, ok);
    repeat (12) begin
      b = 1'($urandom);
      f = ($urandom % 4) == 0;
      tx_bit <= b;
      far_dom <= f;
      // rx follows the wired bus, which lags the transmit path
      tk(11);
      chk(bus_drive_dominant, !b);
      chk(rxd_out, b & !f);
    end
    tx_bit <= 1'b1;
    far_dom <= 1'b0;
    wake_pattern_det <= 1'b1;
    tk(1);
    wake_pattern_det <= 1'b0;
    local_wake_in <= 1'b1;
    tk(10);
    rd(sa, 32'h10, 32'h0, ok);
    rd(ia, 32'h5, 32'h0, ok);
    wr(ca, 32'hc, ok);
    tk(3);
    chk(wake_frame_monitor_en, 1'b1);
    wake_frame <= 1'b1;
    tk(1);
    wake_frame <= 1'b0;
    rd(ia, 32'h2, 32'h2, ok);
    $display("test normal done");
    wr(ca, 32'hb, ok);
    tk(3);
    chk({txd_timeout_en, overtemp_en, bus_bias_on, undervoltage_det_en,
      supply_switch_out}, 5'h07);
    rd(sa, 32'h7, 32'h2, ok);
    tx_bit <= 1'b0;
    tk(8);
    chk({bus_drive_dominant, rxd_out}, 2'h1);
    far_dom <= 1'b1;
    tk(8);
    chk(rxd_out, 1'b0);
    tx_bit <= 1'b1;
    far_dom <= 1'b0;
    wr(ca, 32'h3, ok);
    repeat (3) begin
      tx_supply_undervoltage_level <= 1'b1;
      tk(10);
      tx_supply_undervoltage_level <= 1'b0;
      tk(4);
    end
    logic_ref_undervoltage_level <= 1'b1;
    // bus activity restarts the silence timer before it expires, so the expired filter alone does not force sleep
    repeat (4) begin
      far_dom <= 1'b1;
      tk(3);
      far_dom <= 1'b0;
      tk(25);
    end
    rd(sa, 32'h7, 32'h2, ok);
    tk(60);
    rd(sa, 32'h7, 32'h4, ok);
    chk({supply_switch_out, irq}, 2'h1);
    // release the supply first so stand-by is not forced back to sleep
    logic_ref_undervoltage_level <= 1'b0;
    tk(8);
    rd(ia, 32'h1f, 32'h08, ok);
    $display("test undervoltage done");
    wake_pattern_det <= 1'b1;
    tk(1);
    wake_pattern_det <= 1'b0;
    tk(4);
    rd(sa, 32'h7, 32'h3, ok);
    chk({rxd_out, irq}, 2'h1);
    rd(ia, 32'h1f, 32'h01, ok);
    for (int i = 0; i < 7; i++) begin
      wr(ca, {28'h0, cmd[i]}, ok);
      rd(sa, 32'h7, {29'h0, code[i]}, ok);
    end
    $display("test commands done");
    test_done();
  end
endmodule : can_transceiver_mode_control_tb
bind cantmc_top cantmc_props u_props (.*);
